/* src/pwr_ctl_params.svh */
// Function
// - Low-driver field: 00 off, 11 on
// - Normal regulator low-driver needs bit and 11
// - Low-power regulator low-driver needs bit and 11
// - Backup writes blocked unless enable bit set
// - Threshold codes map ascending 2.1V to 3.1V
// - Detector runs only while enabled
// - Lock makes detector fields read-only
// - Standby clear strobe clears flag, reads 0
// - Wakeup clear strobe clears flag, reads 0
// - Deep sleep becomes standby when selected
// - Regulator low-power during deep sleep if set
// - Register resets to zero, also on standby wake
// - Standby flag set after standby, sticky
// - Wakeup flag set on any wakeup event
// Purpose: constants for the power mode control register
// Assumes: 32-bit Avalon-MM word registers
// Notes: byte offsets
`ifndef PWR_CTL_PARAMS_SVH
`define PWR_CTL_PARAMS_SVH
`define PWR_OFS_CTRL 8'h00
`define PWR_OFS_STATUS 8'h04
`define PWR_CTRL_RESET 32'h0000_0000
`define PWR_CTRL_WMASK 32'h000C_0DF3
`define PWR_BIT_LPREG 0
`define PWR_BIT_STBSEL 1
`define PWR_BIT_WUCLR 2
`define PWR_BIT_STBCLR 3
`define PWR_BIT_DETEN 4
`define PWR_POS_THR 5
`define PWR_BIT_BKPWE 8
`define PWR_BIT_LOW_DRIVER_LOWPOWER_REG 10
`define PWR_BIT_LOW_DRIVER_NORMAL_REG 11
`define PWR_POS_LOW_DRIVER_ENABLE_FIELD 18
`define PWR_LOW_DRIVER_ENABLE_FIELD_ON 2'h3
`define PWR_BIT_STANDBY_STATUS_FLAG 1
`define PWR_BIT_WUF 0
`endif

/* src/pwr_ctl_pkg.sv */
// Purpose: types for the power mode control register
// Assumes: nothing
// Notes: field order matches bit order of the control word
package pwr_ctl_pkg;
	typedef struct packed {
		logic [1:0] low_driver_enable_field;
		logic low_driver_normal_reg;
		logic low_driver_lowpower_reg;
		logic backup_write_enable;
		logic [2:0] detector_threshold;
		logic detector_enable;
		logic standby_select;
		logic regulator_low_power;
	} ctrl_t;
	typedef enum logic [1:0] {
		PM_RUN = 2'b00,
		PM_DEEP = 2'b01,
		PM_STANDBY = 2'b10
	} pmode_t;
endpackage

/* src/power_mode_control.sv */
// Purpose: power mode control register with sleep mode decode
// Assumes: core holds deep-sleep request level while asleep
// Notes: standby wake reset is a one-cycle input pulse
`timescale 1ns/100ps
`include "pwr_ctl_params.svh"
module power_mode_control (
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	input wire logic [7:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic cpu_deep_sleep_request_in,
	input wire logic standby_wake_in,
	input wire logic standby_done_in,
	input wire logic wakeup_event_in,
	input wire logic detector_config_lock_in,
	input wire logic low_voltage_in,
	input wire logic backup_write_req_in,
	output logic backup_write_ok_out,
	output logic [1:0] power_mode_out,
	output logic regulator_low_power_out,
	output logic low_driver_normal_out,
	output logic low_driver_lowpower_out,
	output logic detector_enable_out,
	output logic [2:0] detector_threshold_out,
	output logic standby_status_flag_out,
	output logic wakeup_status_flag_out,
	output logic low_voltage_flag_out
);
	pwr_ctl_pkg::ctrl_t ctrl_q;
	logic ack_q;
	logic standby_status_flag_q;
	logic wuf_q;
	logic lvdf_q;
	logic [31:0] wmask;
	logic wr_ctrl;
	logic wr_stbclr;
	logic wr_wuclr;
	logic ld_on;
	logic [31:0] rd_d;

	function automatic logic [31:0] be_mask(input logic [3:0] be);
		be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction

	function automatic logic [31:0] ctrl_word(input pwr_ctl_pkg::ctrl_t c);
		logic [31:0] w;
		w = `PWR_CTRL_RESET;
		w[`PWR_POS_LOW_DRIVER_ENABLE_FIELD +: 2] = c.low_driver_enable_field;
		w[`PWR_BIT_LOW_DRIVER_NORMAL_REG] = c.low_driver_normal_reg;
		w[`PWR_BIT_LOW_DRIVER_LOWPOWER_REG] = c.low_driver_lowpower_reg;
		w[`PWR_BIT_BKPWE] = c.backup_write_enable;
		w[`PWR_POS_THR +: 3] = c.detector_threshold;
		w[`PWR_BIT_DETEN] = c.detector_enable;
		w[`PWR_BIT_STBSEL] = c.standby_select;
		w[`PWR_BIT_LPREG] = c.regulator_low_power;
		ctrl_word = w;
	endfunction

	// One wait cycle per access; answer on the second edge
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			ack_q <= 1'b0;
		else
			ack_q <= (avs_read_in || avs_write_in) && !ack_q;
	end

	// Registered so the bus sees a clean flop output; high out of reset
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			avs_waitrequest_out <= 1'b1;
		else
			avs_waitrequest_out <= !((avs_read_in || avs_write_in) && !ack_q);
	end

	assign wmask = be_mask(avs_byteenable_in);
	assign wr_ctrl = avs_write_in && ack_q && (avs_address_in == `PWR_OFS_CTRL);
	assign wr_stbclr = wr_ctrl && wmask[`PWR_BIT_STBCLR] && avs_writedata_in[`PWR_BIT_STBCLR];
	assign wr_wuclr = wr_ctrl && wmask[`PWR_BIT_WUCLR] && avs_writedata_in[`PWR_BIT_WUCLR];

	// Zero on reset and on standby wake
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			ctrl_q <= '0;
		else if (standby_wake_in)
			ctrl_q <= '0;
		else if (wr_ctrl)
		begin
			if (wmask[`PWR_POS_LOW_DRIVER_ENABLE_FIELD])
				ctrl_q.low_driver_enable_field <= avs_writedata_in[`PWR_POS_LOW_DRIVER_ENABLE_FIELD +: 2];
			if (wmask[`PWR_BIT_LOW_DRIVER_NORMAL_REG])
			begin
				ctrl_q.low_driver_normal_reg <= avs_writedata_in[`PWR_BIT_LOW_DRIVER_NORMAL_REG];
				ctrl_q.low_driver_lowpower_reg <= avs_writedata_in[`PWR_BIT_LOW_DRIVER_LOWPOWER_REG];
				ctrl_q.backup_write_enable <= avs_writedata_in[`PWR_BIT_BKPWE];
			end
			if (wmask[`PWR_BIT_LPREG])
			begin
				ctrl_q.standby_select <= avs_writedata_in[`PWR_BIT_STBSEL];
				ctrl_q.regulator_low_power <= avs_writedata_in[`PWR_BIT_LPREG];
				if (!detector_config_lock_in)
				begin
					ctrl_q.detector_enable <= avs_writedata_in[`PWR_BIT_DETEN];
					ctrl_q.detector_threshold <= avs_writedata_in[`PWR_POS_THR +: 3];
				end
			end
		end
	end

	// Standby flag sticky, set beats clear
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			standby_status_flag_q <= 1'b0;
		else if (standby_done_in)
			standby_status_flag_q <= 1'b1;
		else if (wr_stbclr)
			standby_status_flag_q <= 1'b0;
	end

	// Wakeup flag sticky, set beats clear
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			wuf_q <= 1'b0;
		else if (wakeup_event_in)
			wuf_q <= 1'b1;
		else if (wr_wuclr)
			wuf_q <= 1'b0;
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			lvdf_q <= 1'b0;
		else
			lvdf_q <= ctrl_q.detector_enable && low_voltage_in;
	end

	// Only code 11 enables; reserved codes act as 00
	assign ld_on = (ctrl_q.low_driver_enable_field == `PWR_LOW_DRIVER_ENABLE_FIELD_ON);

	always_comb
	begin
		rd_d = 32'h0000_0000;
		if (avs_address_in == `PWR_OFS_CTRL)
			rd_d = ctrl_word(ctrl_q);
		else if (avs_address_in == `PWR_OFS_STATUS)
		begin
			rd_d[`PWR_BIT_WUF] = wuf_q;
			rd_d[`PWR_BIT_STANDBY_STATUS_FLAG] = standby_status_flag_q;
			rd_d[2] = lvdf_q;
		end
	end

	// Outputs registered; mode follows request by one cycle
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			avs_readdata_out <= 32'h0000_0000;
			power_mode_out <= pwr_ctl_pkg::PM_RUN;
			regulator_low_power_out <= 1'b0;
			low_driver_normal_out <= 1'b0;
			low_driver_lowpower_out <= 1'b0;
			detector_enable_out <= 1'b0;
			detector_threshold_out <= 3'h0;
			backup_write_ok_out <= 1'b0;
			standby_status_flag_out <= 1'b0;
			wakeup_status_flag_out <= 1'b0;
			low_voltage_flag_out <= 1'b0;
		end
		else
		begin
			avs_readdata_out <= (avs_read_in && !ack_q) ? rd_d : 32'h0000_0000;
			if (!cpu_deep_sleep_request_in)
				power_mode_out <= pwr_ctl_pkg::PM_RUN;
			else if (ctrl_q.standby_select)
				power_mode_out <= pwr_ctl_pkg::PM_STANDBY;
			else
				power_mode_out <= pwr_ctl_pkg::PM_DEEP;
			regulator_low_power_out <= cpu_deep_sleep_request_in && !ctrl_q.standby_select
				&& ctrl_q.regulator_low_power;
			low_driver_normal_out <= ld_on && ctrl_q.low_driver_normal_reg
				&& !ctrl_q.regulator_low_power;
			low_driver_lowpower_out <= ld_on && ctrl_q.low_driver_lowpower_reg
				&& ctrl_q.regulator_low_power;
			// Threshold code passed to analog, ascending
			detector_threshold_out <= ctrl_q.detector_threshold;
			detector_enable_out <= ctrl_q.detector_enable;
			backup_write_ok_out <= backup_write_req_in && ctrl_q.backup_write_enable;
			standby_status_flag_out <= standby_status_flag_q;
			wakeup_status_flag_out <= wuf_q;
			low_voltage_flag_out <= lvdf_q;
		end
	end

	a_backup_gate: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		backup_write_ok_out |-> $past(ctrl_q.backup_write_enable))
		else $error("backup write passed while disabled");
	a_lock_holds: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(detector_config_lock_in && !standby_wake_in) |=> $stable(ctrl_q.detector_threshold))
		else $error("locked threshold changed");
	a_stb_clear: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(wr_stbclr && !standby_done_in) |=> !standby_status_flag_q ##1 !standby_status_flag_out)
		else $error("standby flag not cleared");
	a_wu_clear: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(wr_wuclr && !wakeup_event_in) |=> !wuf_q)
		else $error("wakeup flag not cleared");
	a_standby_mode: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(cpu_deep_sleep_request_in && ctrl_q.standby_select)
		|=> power_mode_out == pwr_ctl_pkg::PM_STANDBY)
		else $error("standby not entered");
	a_wake_reset: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		standby_wake_in |=> ctrl_word(ctrl_q) == `PWR_CTRL_RESET)
		else $error("control not reset on wake");
	a_wu_set: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		wakeup_event_in |=> wuf_q ##1 wakeup_status_flag_out)
		else $error("wakeup flag not set");
	a_ld_reserved: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(ctrl_q.low_driver_enable_field != `PWR_LOW_DRIVER_ENABLE_FIELD_ON)
		|=> !low_driver_normal_out && !low_driver_lowpower_out)
		else $error("low driver on with reserved code");
	a_det_off: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		!ctrl_q.detector_enable |=> !lvdf_q)
		else $error("detector active while disabled");
	// Bus answer after one wait cycle
	a_wait_single: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		((avs_read_in || avs_write_in) && !ack_q) |=> !avs_waitrequest_out)
		else $error("bus answer missing");
	// Answer stands one cycle only
	a_wait_release: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		!avs_waitrequest_out |=> avs_waitrequest_out)
		else $error("waitrequest low too long");
	// Read data idle at zero
	a_rdata_idle: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		!avs_read_in |=> avs_readdata_out == 32'h0000_0000)
		else $error("read data not idle");
	a_deep_mode: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(cpu_deep_sleep_request_in && !ctrl_q.standby_select) |=> power_mode_out == pwr_ctl_pkg::PM_DEEP)
		else $error("deep sleep not entered");
	a_run_mode: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		!cpu_deep_sleep_request_in |=> power_mode_out == pwr_ctl_pkg::PM_RUN)
		else $error("run mode not restored");
	a_lp_on: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(cpu_deep_sleep_request_in && !ctrl_q.standby_select && ctrl_q.regulator_low_power) |=> regulator_low_power_out)
		else $error("regulator not low power");
	a_lp_off: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		!ctrl_q.regulator_low_power |=> !regulator_low_power_out)
		else $error("regulator low power while bit clear");
	a_lp_standby: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		ctrl_q.standby_select |=> !regulator_low_power_out)
		else $error("regulator low power in standby");
	a_ld_normal: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(ld_on && ctrl_q.low_driver_normal_reg && !ctrl_q.regulator_low_power) |=> low_driver_normal_out)
		else $error("normal low driver missing");
	a_ld_normal_off: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		!ctrl_q.low_driver_normal_reg |=> !low_driver_normal_out)
		else $error("normal low driver without bit");
	a_ld_lowpower: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(ld_on && ctrl_q.low_driver_lowpower_reg && ctrl_q.regulator_low_power) |=> low_driver_lowpower_out)
		else $error("low-power low driver missing");
	a_ld_lowpower_off: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		!ctrl_q.low_driver_lowpower_reg |=> !low_driver_lowpower_out)
		else $error("low-power low driver without bit");
	a_backup_pass: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(backup_write_req_in && ctrl_q.backup_write_enable) |=> backup_write_ok_out)
		else $error("backup write refused while enabled");
	a_backup_block: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		!ctrl_q.backup_write_enable |=> !backup_write_ok_out)
		else $error("backup write passed while blocked");
	a_thr_copy: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		1'b1 |=> detector_threshold_out == $past(ctrl_q.detector_threshold))
		else $error("threshold code altered");
	a_det_on: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		ctrl_q.detector_enable |=> detector_enable_out)
		else $error("detector enable lost");
	a_det_follow: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(ctrl_q.detector_enable && low_voltage_in) |=> lvdf_q)
		else $error("low voltage not reported");
	a_lock_enable: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(detector_config_lock_in && !standby_wake_in) |=> $stable(ctrl_q.detector_enable))
		else $error("locked enable changed");
	a_stb_set: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		standby_done_in |=> standby_status_flag_q ##1 standby_status_flag_out)
		else $error("standby flag not set");
	a_stb_hold: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(standby_status_flag_q && !wr_stbclr) |=> standby_status_flag_q)
		else $error("standby flag lost");
	a_wu_hold: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(wuf_q && !wr_wuclr) |=> wuf_q)
		else $error("wakeup flag lost");
	a_stb_read: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(avs_read_in && !ack_q && avs_address_in == `PWR_OFS_STATUS) |=> avs_readdata_out[`PWR_BIT_STANDBY_STATUS_FLAG] == $past(standby_status_flag_q))
		else $error("standby flag read wrong");
	a_wu_read: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
		(avs_read_in && !ack_q && avs_address_in == `PWR_OFS_STATUS) |=> avs_readdata_out[`PWR_BIT_WUF] == $past(wuf_q))
		else $error("wakeup flag read wrong");
endmodule

/* test/cpu_sleep_model.sv */
// Purpose: core model that raises the deep-sleep request
// Assumes: one clock, async active-low reset
// Notes: the level is held for the whole sleep, as a core does
`timescale 1ns/100ps
module cpu_sleep_model (
	input wire logic ref_clk_in,
	input wire logic arst_n_in,
	input wire logic sleep_cmd_in,
	output logic deep_sleep_request_out
);
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			deep_sleep_request_out <= 1'b0;
		else
			deep_sleep_request_out <= sleep_cmd_in;
	end
endmodule

/* test/power_mode_control_bench.sv */
// Purpose: bench for the power mode control register
// Assumes: design answers each bus access after one wait cycle
// Notes: byte enables stay full, so lane gating is not exercised
`timescale 1ns/100ps
`include "pwr_ctl_params.svh"
module power_mode_control_bench;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] adr = 8'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdat = 32'h0000_0000;
	logic sleep_cmd = 1'b0;
	logic stb_wake = 1'b0;
	logic stb_done = 1'b0;
	logic wu_evt = 1'b0;
	logic lock = 1'b0;
	logic low_v = 1'b0;
	logic bkp_req = 1'b0;
	logic [31:0] rdat;
	logic [31:0] q;
	logic wait_r, sleep_req, bkp_ok, reg_lp, ld_n, ld_l, det_en, f_stb, f_wu, f_lv;
	logic [1:0] mode;
	logic [2:0] thr;
	int n_mismatch = 0;
	int n_checks = 0;
	always #2.5 clk = ~clk;
	power_mode_control i_power_mode_control (.ref_clk_in(clk), .arst_n_in(rst_n),
		.avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat),
		.avs_byteenable_in(4'hF), .avs_readdata_out(rdat), .avs_waitrequest_out(wait_r),
		.cpu_deep_sleep_request_in(sleep_req), .standby_wake_in(stb_wake),
		.standby_done_in(stb_done), .wakeup_event_in(wu_evt), .detector_config_lock_in(lock),
		.low_voltage_in(low_v), .backup_write_req_in(bkp_req), .backup_write_ok_out(bkp_ok),
		.power_mode_out(mode), .regulator_low_power_out(reg_lp), .low_driver_normal_out(ld_n),
		.low_driver_lowpower_out(ld_l), .detector_enable_out(det_en),
		.detector_threshold_out(thr), .standby_status_flag_out(f_stb),
		.wakeup_status_flag_out(f_wu), .low_voltage_flag_out(f_lv));
	cpu_sleep_model i_cpu_sleep_model (.ref_clk_in(clk), .arst_n_in(rst_n),
		.sleep_cmd_in(sleep_cmd), .deep_sleep_request_out(sleep_req));
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		adr <= a;
		wr <= w;
		rd <= ~w;
		wdat <= d;
		@(posedge clk);
		while (wait_r !== 1'b0 && n < 20)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= 20)
		begin
			n_mismatch++;
			end_of_test();
		end
		q = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
		bus(1'b0, a, 32'h0000_0000);
		chk(what, exp, q);
	endtask
	initial
	begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		end_of_test();
	end
	initial
	begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rchk(`PWR_OFS_CTRL, `PWR_CTRL_RESET, "ctrl reset");
		rchk(`PWR_OFS_STATUS, 32'h0000_0000, "status reset");
		bus(1'b1, 8'h10, 32'h0000_0DF3);
		rchk(8'h10, 32'h0000_0000, "unmapped");
		bkp_req <= 1'b1;
		repeat (2) @(posedge clk);
		chk("backup blocked", 32'h0000_0000, 32'(bkp_ok));
		// Reserved positions written as zero only
		bus(1'b1, `PWR_OFS_CTRL, 32'h000C_0DFF);
		rchk(`PWR_OFS_CTRL, 32'h000C_0DF3, "clear bits read 0");
		chk("backup det", 32'h0000_001F, 32'({bkp_ok, det_en, thr}));
		lock <= 1'b1;
		bus(1'b1, `PWR_OFS_CTRL, 32'h0000_0000);
		rchk(`PWR_OFS_CTRL, 32'h0000_00F0, "locked");
		lock <= 1'b0;
		for (int i = 0; i < 8; i++)
		begin
			bus(1'b1, `PWR_OFS_CTRL, 32'(i * 32 + 16));
			// Outputs move one edge after the write lands; look mid-cycle
			@(negedge clk);
			chk("threshold", 32'(8 + i), 32'({det_en, thr}));
			@(posedge clk);
		end
		low_v <= 1'b1;
		repeat (3) @(posedge clk);
		rchk(`PWR_OFS_STATUS, 32'h0000_0004, "lv on");
		bus(1'b1, `PWR_OFS_CTRL, 32'h0000_0000);
		rchk(`PWR_OFS_STATUS, 32'h0000_0000, "lv off");
		low_v <= 1'b0;
		// Every low-driver code with each regulator and mode choice
		for (int i = 0; i < 16; i++)
		begin
			bus(1'b1, `PWR_OFS_CTRL, 32'((i % 4) * 262144 + 3072 + (i / 8) * 2 + (i / 4) % 2));
			sleep_cmd <= 1'b1;
			repeat (3) @(posedge clk);
			chk("sleep", 32'({(i >= 8) ? 2'h2 : 2'h1, i < 8 && (i / 4) % 2 == 1,
				i % 4 == 3 && (i / 4) % 2 == 0, i % 4 == 3 && (i / 4) % 2 == 1}), 32'({mode,
				reg_lp, ld_n, ld_l}));
			sleep_cmd <= 1'b0;
			repeat (3) @(posedge clk);
			chk("awake", 32'h0000_0000, 32'(mode));
		end
		stb_done <= 1'b1;
		wu_evt <= 1'b1;
		@(posedge clk);
		stb_done <= 1'b0;
		wu_evt <= 1'b0;
		repeat (3) @(posedge clk);
		rchk(`PWR_OFS_STATUS, 32'h0000_0003, "flags set");
		bus(1'b1, `PWR_OFS_CTRL, 32'h0000_0000);
		rchk(`PWR_OFS_STATUS, 32'h0000_0003, "zero no effect");
		bus(1'b1, `PWR_OFS_CTRL, 32'h0000_0008);
		rchk(`PWR_OFS_STATUS, 32'h0000_0001, "standby clear");
		bus(1'b1, `PWR_OFS_CTRL, 32'h0000_0004);
		rchk(`PWR_OFS_STATUS, 32'h0000_0000, "wakeup clear");
		bus(1'b1, `PWR_OFS_CTRL, 32'h0000_0113);
		stb_wake <= 1'b1;
		@(posedge clk);
		stb_wake <= 1'b0;
		@(posedge clk);
		rchk(`PWR_OFS_CTRL, `PWR_CTRL_RESET, "wake reset");
		end_of_test();
	end
endmodule
